// ===== pssr_bank.v
// processor status register bank for one tile: control, boot state, security,
// ring oscillators, memory capacity and debug thread-status snapshot
// assumes a single-cycle status read/write port from the core on i_clk, and
// ring oscillator taps arriving asynchronously as levels
//
// Contract
// - eight-bit transmit data delay in pll cycles, resets to zero
// - tx clock high at count equal divider, low at divider shifted right one
// - ethernet peripheral ports enabled only while enable bit set, reset zero
// - dynamic mode divides only while all active threads paused, else always
// - divider enable bit divides pll clock for low power, reset zero
// - usb transceiver uses utmi when select is one, ulpi when zero
// - ulpi support module active only while its control bit set
// - boot state read-only: processor number, flags and pll mode pins; code holds a boot override bit (8) and no pll mode pins
// - once security top bit set, further security writes refused
// - per-sector otp lock field, plus global lock of all sectors
// - security bits block jtag config, jtag debug port, global debug
// - security bit forces boot from otp; another bit enables otp redundancy
// - security register loaded from otp copy
// - core and peripheral oscillators have separate run bits, reset zero
// - four sixteen-bit read-only counts, untouched by system reset
// - counters ordered tile cell, tile wire, peripheral cell, peripheral wire
// - oscillators free-running and asynchronous, usable as random source
// - memory capacity in bytes read-only in upper thirty bits
// - debugger entry captures thread status incl asid, issue, fast, paused
// - snapshot low bits hold kernel, interrupt, event-seq, irq and event enables
`include "pssr_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module pssr_bank #(
	parameter [29:0] MEM_CAP_WORDS = 30'h0001_0000,
	parameter        DIV_W         = 9
) (
	input  wire        i_clk,
	input  wire        i_reset_n,
	// status register port
	input  wire        i_ps_wr,
	input  wire        i_ps_rd,
	input  wire [15:0] i_ps_res_id,
	input  wire [31:0] i_ps_wdata,
	output reg  [31:0] o_ps_rdata,
	output reg         o_ps_rvalid,
	// boot state straps and otp load
	input  wire [7:0]  i_proc_num,
	input  wire [5:0]  i_boot_flags,
	input  wire        i_boot_override,
	input  wire        i_otp_load,
	input  wire [31:0] i_otp_security,
	// thread status capture
	input  wire        i_dbg_enter,
	input  wire [31:0] i_thread_status,
	input  wire        i_all_paused,
	// pll-side tick and ring oscillator taps
	input  wire        i_pll_tick,
	input  wire [3:0]  i_osc_tap,
	// controls to the tile
	output reg  [7:0]  o_tx_data_delay,
	output reg         o_tx_clk,
	output reg         o_rgmii_port_en,
	output reg         o_clk_div_active,
	output reg         o_usb_utmi_sel,
	output reg         o_ulpi_assist_en,
	output reg  [3:0]  o_otp_sector_lock,
	output reg         o_otp_redundancy_en,
	output reg         o_otp_boot_force,
	output reg         o_jtag_cfg_block,
	output reg         o_jtag_tap_block,
	output reg         o_global_dbg_block,
	output reg  [1:0]  o_osc_run
);

	reg  [31:0]      tile_ctrl_ff;
	reg  [31:0]      security_ff;
	reg  [31:0]      osc_ctrl_ff;
	reg  [31:0]      dbg_status_ff;
	reg  [31:0]      boot_state_ff;
	reg              boot_cap_ff;
	reg  [DIV_W-1:0] tx_cnt_ff;
	reg  [3:0]       sync1_ff;
	reg  [3:0]       sync2_ff;
	reg  [3:0]       sync3_ff;
	reg  [3:0]       tap_lvl_ff;
	reg  [15:0]      osc_cnt_ff [0:3];
	reg  [31:0]      nxt_rdata;
	wire [7:0]       reg_num;
	wire             res_ok;
	wire [DIV_W-1:0] tx_div;

	assign reg_num = i_ps_res_id[15:8];
	assign res_ok  = (i_ps_res_id[7:0] == `PSSR_RES_TYPE);
	assign tx_div  = tile_ctrl_ff[`PSSR_TXDIV_HI:`PSSR_TXDIV_LO];

	// decode a write strobe for one register number
	function wr_hit;
		input       wr;
		input       ok;
		input [7:0] num;
		input [7:0] want;
		begin
			wr_hit = wr & ok & (num == want);
		end
	endfunction

	// control and debug registers, masked writes
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tile_ctrl_ff  <= `PSSR_CTRL_RESET;
			osc_ctrl_ff   <= `PSSR_OSC_RESET;
			dbg_status_ff <= `PSSR_DBG_RESET;
		end else begin
			if (wr_hit(i_ps_wr, res_ok, reg_num, `PSSR_REG_TILE_CTRL)) begin
				tile_ctrl_ff <= i_ps_wdata & `PSSR_CTRL_MASK;
			end
			if (wr_hit(i_ps_wr, res_ok, reg_num, `PSSR_REG_OSC_CTRL)) begin
				osc_ctrl_ff <= i_ps_wdata & `PSSR_OSC_MASK;
			end
			// capture wins over a debugger write in the same cycle
			if (i_dbg_enter) begin
				dbg_status_ff <= i_thread_status & `PSSR_DBG_MASK;
			end else if (wr_hit(i_ps_wr, res_ok, reg_num, `PSSR_REG_DBG_STATUS)) begin
				dbg_status_ff <= (dbg_status_ff & ~`PSSR_DBG_WMASK)
					| (i_ps_wdata & `PSSR_DBG_WMASK);
			end
		end
	end

	// security register: otp load, software writes until locked
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			security_ff <= 32'h0000_0000;
		end else if (i_otp_load) begin
			security_ff <= i_otp_security & `PSSR_SEC_MASK;
		end else if (wr_hit(i_ps_wr, res_ok, reg_num, `PSSR_REG_SECURITY)
			&& !security_ff[`PSSR_SEC_WLOCK]) begin
			security_ff <= i_ps_wdata & `PSSR_SEC_MASK;
		end
	end

	// boot straps caught once after reset release
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			boot_state_ff <= 32'h0000_0000;
			boot_cap_ff   <= 1'b0;
		end else if (!boot_cap_ff) begin
			boot_cap_ff   <= 1'b1;
			boot_state_ff <= {8'h00, i_proc_num, 7'h00, i_boot_override,
				2'b00, i_boot_flags} & `PSSR_BOOT_MASK;
		end
	end

	// tx clock: counter on pll tick, rise at divider, fall at divider>>1
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_cnt_ff <= {DIV_W{1'b0}};
			o_tx_clk  <= 1'b0;
		end else if (i_pll_tick) begin
			if (tx_cnt_ff >= tx_div) begin
				tx_cnt_ff <= {DIV_W{1'b0}};
			end else begin
				tx_cnt_ff <= tx_cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
			end
			if (tx_cnt_ff == tx_div) begin
				o_tx_clk <= 1'b1;
			end else if (tx_cnt_ff == (tx_div >> 1)) begin
				o_tx_clk <= 1'b0;
			end
		end
	end

	// oscillator taps: three-stage sync, level accepted once second and third agree
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_ff   <= 4'h0;
			sync2_ff   <= 4'h0;
			sync3_ff   <= 4'h0;
			tap_lvl_ff <= 4'h0;
		end else begin
			sync1_ff   <= i_osc_tap;
			sync2_ff   <= sync1_ff;
			sync3_ff   <= sync2_ff;
			// agreeing stages update the level, a disagreement holds it
			tap_lvl_ff <= (sync2_ff & sync3_ff) | (tap_lvl_ff & (sync2_ff | sync3_ff));
		end
	end

	// counters without reset; index order fixes the register mapping
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_osc
			wire run;
			assign run = (g < 2) ? osc_ctrl_ff[`PSSR_OSC_CORE_EN]
				: osc_ctrl_ff[`PSSR_OSC_PERI_EN];
			// power-up value zero; system reset leaves the count alone
			initial osc_cnt_ff[g] = 16'h0000;
			// count an accepted rising level of the tap
			always @(posedge i_clk) begin
				if (run && sync2_ff[g] && sync3_ff[g] && !tap_lvl_ff[g]) begin
					osc_cnt_ff[g] <= osc_cnt_ff[g] + 16'h0001;
				end
			end
		end
	endgenerate

	// read mux; unmapped numbers and reserved bits read zero
	always @* begin
		nxt_rdata = 32'h0000_0000;
		if (res_ok) begin
			case (reg_num)
				`PSSR_REG_TILE_CTRL:  nxt_rdata = tile_ctrl_ff;
				`PSSR_REG_BOOT_STATE: nxt_rdata = boot_state_ff;
				`PSSR_REG_SECURITY:   nxt_rdata = security_ff;
				`PSSR_REG_OSC_CTRL:   nxt_rdata = osc_ctrl_ff;
				`PSSR_REG_OSC_TCELL:  nxt_rdata = {16'h0000, osc_cnt_ff[0]};
				`PSSR_REG_OSC_TWIRE:  nxt_rdata = {16'h0000, osc_cnt_ff[1]};
				`PSSR_REG_OSC_PCELL:  nxt_rdata = {16'h0000, osc_cnt_ff[2]};
				`PSSR_REG_OSC_PWIRE:  nxt_rdata = {16'h0000, osc_cnt_ff[3]};
				`PSSR_REG_MEM_CAP:    nxt_rdata = {MEM_CAP_WORDS, 2'b00};
				`PSSR_REG_DBG_STATUS: nxt_rdata = dbg_status_ff;
				default:              nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	// registered read answer, one cycle after the request
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_ps_rdata  <= 32'h0000_0000;
			o_ps_rvalid <= 1'b0;
		end else begin
			o_ps_rvalid <= i_ps_rd;
			if (i_ps_rd) begin
				o_ps_rdata <= nxt_rdata;
			end
		end
	end

	// control outputs registered from the bank
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_tx_data_delay     <= 8'h00;
			o_rgmii_port_en     <= 1'b0;
			o_clk_div_active    <= 1'b0;
			o_usb_utmi_sel      <= 1'b0;
			o_ulpi_assist_en    <= 1'b0;
			o_otp_sector_lock   <= 4'h0;
			o_otp_redundancy_en <= 1'b0;
			o_otp_boot_force    <= 1'b0;
			o_jtag_cfg_block    <= 1'b0;
			o_jtag_tap_block    <= 1'b0;
			o_global_dbg_block  <= 1'b0;
			o_osc_run           <= 2'b00;
		end else begin
			o_tx_data_delay  <= tile_ctrl_ff[`PSSR_TXDLY_HI:`PSSR_TXDLY_LO];
			o_rgmii_port_en  <= tile_ctrl_ff[`PSSR_RGMII_EN];
			o_clk_div_active <= tile_ctrl_ff[`PSSR_DIV_EN]
				& (~tile_ctrl_ff[`PSSR_DIV_DYN] | i_all_paused);
			o_usb_utmi_sel   <= tile_ctrl_ff[`PSSR_UTMI_SEL];
			o_ulpi_assist_en <= tile_ctrl_ff[`PSSR_ULPI_EN];
			o_otp_sector_lock <= security_ff[`PSSR_SEC_SECT_HI:`PSSR_SEC_SECT_LO]
				| {4{security_ff[`PSSR_SEC_OTP_ALL]}};
			o_otp_redundancy_en <= security_ff[`PSSR_SEC_REDUND];
			o_otp_boot_force    <= security_ff[`PSSR_SEC_OTPBOOT];
			o_jtag_cfg_block    <= security_ff[`PSSR_SEC_NOJCFG];
			o_jtag_tap_block    <= security_ff[`PSSR_SEC_NOTAP];
			o_global_dbg_block  <= security_ff[`PSSR_SEC_NODBG];
			o_osc_run           <= osc_ctrl_ff[1:0];
		end
	end

endmodule

`default_nettype wire

// ===== pssr_consts.vh
// processor status bank constants: register numbers, field positions, reset values
// assumes inclusion by pssr_bank.v only
`ifndef PSSR_CONSTS_VH
`define PSSR_CONSTS_VH
// register numbers
`define PSSR_REG_TILE_CTRL   8'h02
`define PSSR_REG_BOOT_STATE  8'h03
`define PSSR_REG_SECURITY    8'h05
`define PSSR_REG_OSC_CTRL    8'h06
`define PSSR_REG_OSC_TCELL   8'h07
`define PSSR_REG_OSC_TWIRE   8'h08
`define PSSR_REG_OSC_PCELL   8'h09
`define PSSR_REG_OSC_PWIRE   8'h0a
`define PSSR_REG_MEM_CAP     8'h0c
`define PSSR_REG_DBG_STATUS  8'h10
// resource identifier low byte
`define PSSR_RES_TYPE        8'h0b
// field masks (reserved bits read zero, ignore writes) and reset values
`define PSSR_CTRL_MASK       32'h03ff_ff36
`define PSSR_SEC_MASK        32'h8000_5fb1
`define PSSR_OSC_MASK        32'h0000_0003
`define PSSR_DBG_WMASK       32'h0000_06df
`define PSSR_DBG_MASK        32'h0000_07df
`define PSSR_BOOT_MASK       32'h00ff_013f
`define PSSR_CTRL_RESET      32'h0000_0000
`define PSSR_OSC_RESET       32'h0000_0000
`define PSSR_DBG_RESET       32'h0000_0000
// tile control fields
`define PSSR_TXDLY_HI        25
`define PSSR_TXDLY_LO        18
`define PSSR_TXDIV_HI        17
`define PSSR_TXDIV_LO        9
`define PSSR_RGMII_EN        8
`define PSSR_DIV_DYN         5
`define PSSR_DIV_EN          4
`define PSSR_UTMI_SEL        2
`define PSSR_ULPI_EN         1
// security fields
`define PSSR_SEC_WLOCK       31
`define PSSR_SEC_NODBG       14
`define PSSR_SEC_OTP_ALL     12
`define PSSR_SEC_SECT_HI     11
`define PSSR_SEC_SECT_LO     8
`define PSSR_SEC_REDUND      7
`define PSSR_SEC_OTPBOOT     5
`define PSSR_SEC_NOJCFG      4
`define PSSR_SEC_NOTAP       0
// oscillator control fields
`define PSSR_OSC_CORE_EN     1
`define PSSR_OSC_PERI_EN     0
`endif

// ===== pssr_bank_properties.sv
// checker for the status register port and control outputs
// assumes binding to pssr_bank, one clock i_clk
`timescale 1ns/1ps
`default_nettype none
module pssr_bank_props #(
	parameter [29:0] MEM_CAP_WORDS = 30'h0001_0000
) (
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	input wire logic        i_ps_rd,
	input wire logic        i_ps_wr,
	input wire logic [15:0] i_ps_res_id,
	input wire logic [31:0] i_ps_wdata,
	input wire logic [31:0] o_ps_rdata,
	input wire logic        o_ps_rvalid,
	input wire logic        i_otp_load,
	input wire logic [31:0] i_otp_security,
	input wire logic [7:0]  o_tx_data_delay,
	input wire logic        o_rgmii_port_en,
	input wire logic        o_usb_utmi_sel,
	input wire logic [1:0]  o_osc_run,
	input wire logic [3:0]  o_otp_sector_lock,
	input wire logic        o_otp_boot_force
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// decoded writes
	wire logic wr_ctrl = i_ps_wr && i_ps_res_id == 16'h020b;
	wire logic wr_osc = i_ps_wr && i_ps_res_id == 16'h060b;
	property p_rd_ans;
		i_ps_rd && i_ps_res_id[7:0] == 8'h0b |=> o_ps_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_tx_dly;
		wr_ctrl |-> ##2 o_tx_data_delay == $past(i_ps_wdata[25:18], 2);
	endproperty
	a_tx_dly: assert property (p_tx_dly) else $error("tx delay wrong");
	property p_port_en;
		wr_ctrl |-> ##2 o_rgmii_port_en == $past(i_ps_wdata[8], 2);
	endproperty
	a_port_en: assert property (p_port_en) else $error("port enable wrong");
	property p_utmi;
		wr_ctrl |-> ##2 o_usb_utmi_sel == $past(i_ps_wdata[2], 2);
	endproperty
	a_utmi: assert property (p_utmi) else $error("usb select wrong");
	property p_osc;
		wr_osc |-> ##2 o_osc_run == $past(i_ps_wdata[1:0], 2);
	endproperty
	a_osc: assert property (p_osc) else $error("osc run wrong");
	property p_all_lock;
		i_otp_load && i_otp_security[12] |-> ##2 o_otp_sector_lock == 4'hf;
	endproperty
	a_all_lock: assert property (p_all_lock) else $error("global lock missed");
	property p_otp_boot;
		i_otp_load |-> ##2 o_otp_boot_force == $past(i_otp_security[5], 2);
	endproperty
	a_otp_boot: assert property (p_otp_boot) else $error("otp boot wrong");
	property p_mem;
		o_ps_rvalid && $past(i_ps_rd) && $past(i_ps_res_id) == 16'h0c0b
			|-> o_ps_rdata == {MEM_CAP_WORDS, 2'b00};
	endproperty
	a_mem: assert property (p_mem) else $error("capacity wrong");
	property p_osc_resv;
		o_ps_rvalid && $past(i_ps_rd) && $past(i_ps_res_id) == 16'h060b
			|-> o_ps_rdata[31:2] == 30'h0;
	endproperty
	a_osc_resv: assert property (p_osc_resv) else $error("reserved bits set");
	// main scenarios reached
	c_ctrl: cover property (wr_ctrl);
	c_otp: cover property (i_otp_load);
	c_rd: cover property (o_ps_rvalid);
endmodule
bind pssr_bank pssr_bank_props #(.MEM_CAP_WORDS(MEM_CAP_WORDS)) pssr_bank_props_inst (.*);
`default_nettype wire

// ===== pssr_bank_tb_top.sv
// self-checking bench for the status register bank
// assumes pssr_bank with default parameters, checker bound
`timescale 1ns/1ps
`default_nettype none
module pssr_bank_tb_top;
	logic        i_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_ps_wr = 1'b0;
	logic        i_ps_rd = 1'b0;
	logic [15:0] i_ps_res_id = 16'h0;
	logic [31:0] i_ps_wdata = 32'h0;
	logic [7:0]  i_proc_num = 8'h5a;
	logic [5:0]  i_boot_flags = 6'h2d;
	logic        i_boot_override = 1'b1;
	logic        i_otp_load = 1'b0;
	logic [31:0] i_otp_security = 32'hffff_ffff;
	logic        i_dbg_enter = 1'b0;
	logic [31:0] i_thread_status = 32'hffff_ffff;
	logic        i_all_paused = 1'b0;
	logic        i_pll_tick = 1'b1;
	logic [3:0]  i_osc_tap = 4'h0;
	wire  [31:0] o_ps_rdata;
	wire  [7:0]  o_tx_data_delay;
	wire  [3:0]  o_otp_sector_lock;
	wire  [1:0]  o_osc_run;
	wire         o_ps_rvalid, o_tx_clk, o_rgmii_port_en, o_clk_div_active, o_usb_utmi_sel;
	wire         o_ulpi_assist_en, o_otp_redundancy_en, o_otp_boot_force;
	wire         o_jtag_cfg_block, o_jtag_tap_block, o_global_dbg_block;
	int          failures = 0;
	int          checked = 0;
	int          cyc = 0;
	int          n;
	logic        prev;
	logic [31:0] keep;
	pssr_bank pssr_bank_inst (.*);
	// clock and free-running oscillator taps
	always #2.5 i_clk = ~i_clk;
	always #13.1 i_osc_tap = i_osc_tap + 4'h1;
	task automatic results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] r, input logic [31:0] d);
		tick(1);
		i_ps_wr = 1'b1;
		i_ps_res_id = {r, 8'h0b};
		i_ps_wdata = d;
		tick(1);
		i_ps_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] r, input logic [31:0] e, input logic [31:0] m);
		tick(1);
		i_ps_rd = 1'b1;
		i_ps_res_id = {r, 8'h0b};
		tick(1);
		i_ps_rd = 1'b0;
		chk("rvalid", 32'h1, {31'h0, o_ps_rvalid});
		chk($sformatf("reg %h", r), e, o_ps_rdata & m);
		keep = o_ps_rdata;
	endtask
	// hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			results();
		end
	end
	initial begin
		tick(2);
		i_reset_n = 1'b1;
		rd(8'h02, 32'h0, 32'hffff_ffff);
		rd(8'h06, 32'h0, 32'hffff_ffff);
		rd(8'h03, 32'h005a_012d, 32'hffff_ffff);
		rd(8'h0c, 32'h0004_0000, 32'hffff_ffff);
		rd(8'h04, 32'h0, 32'hffff_ffff);
		// all control fields, reserved bits dropped
		wr(8'h02, 32'hffff_ffff);
		rd(8'h02, 32'h03ff_ff36, 32'hffff_ffff);
		chk("ctrl outs", 32'hffe, {o_tx_data_delay, o_rgmii_port_en, o_usb_utmi_sel,
			o_ulpi_assist_en, o_clk_div_active});
		i_all_paused = 1'b1;
		tick(2);
		chk("div dyn", 32'h1, {31'h0, o_clk_div_active});
		i_all_paused = 1'b0;
		wr(8'h02, 32'h0000_0010);
		tick(1);
		chk("div static", 32'h1, {31'h0, o_clk_div_active});
		// divide by four: ten rises in forty ticks
		wr(8'h02, 32'h0000_0600);
		tick(4);
		n = 0;
		repeat (40) begin
			prev = o_tx_clk;
			tick(1);
			if (!prev && o_tx_clk) n++;
		end
		chk("tx rises", 32'd10, n);
		// security: sector lock, otp load, write lock
		wr(8'h05, 32'h0000_0a00);
		tick(1);
		chk("sector lock", 32'ha, {28'h0, o_otp_sector_lock});
		i_otp_load = 1'b1;
		tick(1);
		i_otp_load = 1'b0;
		tick(1);
		chk("sec outs", 32'h1ff, {o_otp_sector_lock, o_otp_redundancy_en, o_otp_boot_force,
			o_jtag_cfg_block, o_jtag_tap_block, o_global_dbg_block});
		wr(8'h05, 32'h0);
		rd(8'h05, 32'h8000_5fb1, 32'hffff_ffff);
		// thread status snapshot
		i_dbg_enter = 1'b1;
		tick(1);
		i_dbg_enter = 1'b0;
		rd(8'h10, 32'h0000_07df, 32'hffff_ffff);
		wr(8'h10, 32'h0);
		rd(8'h10, 32'h0000_0100, 32'hffff_ffff);
		// oscillators: run core only, stop, settle, read
		wr(8'h06, 32'h2);
		rd(8'h06, 32'h2, 32'hffff_ffff);
		tick(40);
		wr(8'h06, 32'h0);
		tick(10);
		for (int r = 7; r <= 10; r++) begin
			rd(r[7:0], 32'h0, 32'hffff_0000);
		end
		rd(8'h09, 32'h0, 32'hffff_ffff);
		rd(8'h07, 32'h0, 32'hffff_0000);
		n = keep[15:0];
		chk("core count ran", 32'h1, {31'h0, (n != 0)});
		tick(20);
		rd(8'h07, n, 32'h0000_ffff);
		results();
	end
endmodule
`default_nettype wire
